// ---- logic/lsp_control.sv ----
// LNB supply protection and diagnostic control, top module
`include "lsp_map.svh"
module lsp_control
  import lsp_pkg::*;
#(
  parameter int TON_CYC = `LSP_TON_CYC,
  parameter int PROTECT_OFF_TIME_CYC = `LSP_PROTECT_OFF_TIME_CYC,
  parameter int CNT_W = 25
) (
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic clk_en_i,
  // Tone control
  input wire logic tone_envelope_in_i,
  input wire logic external_tone_mode_i,
  input wire logic tone_on_bit_i,
  // Register writes and status read from the serial interface
  input wire logic voltage_level_we_i,
  input wire logic [7:0] voltage_level_wdata_i,
  input wire logic [1:0] pulsed_limit_select_i,
  input wire logic overload_recovery_bit_i,
  input wire logic thermal_recovery_bit_i,
  input wire logic diagnostic_rd_i,
  // Analog monitors
  input wire logic undervoltage_lockout_i,
  input wire logic supply_low_detector_i,
  input wire logic overtemp_det_i,
  input wire logic [1:0] overload_det_i,
  // Outputs
  output logic tone_out_o,
  output logic tone_active_o,
  output logic [7:0] voltage_level_reg_o,
  output logic [1:0] output_enable_o,
  output logic converter_enable_o,
  output logic [3:0] diagnostic_reg_o,
  output logic fault_n_out_o
);

  // ==========================================================
  // Reset release and pin synchronisers
  logic [1:0] rst_sync_r;
  logic rst_n;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  // Analog inputs are asynchronous; second and third stage agreement rejects glitches
  localparam int NS = 6;
  logic [NS-1:0] pin_raw;
  logic [NS-1:0] s1_r, s2_r, s3_r, pin_r;
  logic [NS-1:0] pin_nxt;
  assign pin_raw = {overload_det_i, overtemp_det_i, supply_low_detector_i,
                    undervoltage_lockout_i, tone_envelope_in_i};
  genvar g;
  generate
    for (g = 0; g < NS; g++) begin : g_sync
      always_comb begin
        pin_nxt[g] = (s2_r[g] == s3_r[g]) ? s2_r[g] : pin_r[g];
      end
    end
  endgenerate
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      pin_r <= '0;
    end else if (clk_en_i) begin
      s1_r <= pin_raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
      pin_r <= pin_nxt;
    end
  end
  logic env, undervoltage_lockout, slow, otemp;
  logic [1:0] oload;
  assign env = pin_r[0];
  assign undervoltage_lockout = pin_r[1];
  assign slow = pin_r[2];
  assign otemp = pin_r[3];
  assign oload = pin_r[5:4];

  // ==========================================================
  // Envelope tone gating
  localparam int TON_D = `LSP_TONE_ON_CYC;
  localparam int PROTECT_OFF_TIME_D = `LSP_TONE_OFF_CYC;
  localparam int HALF = `LSP_TONE_HALF_CYC;
  logic tone_act_r, tone_act_nxt;
  logic [10:0] dly_r, dly_nxt;
  logic [9:0] ph_r, ph_nxt;
  logic tone_r, tone_nxt;
  logic gate;
  assign gate = tone_on_bit_i && !external_tone_mode_i && !undervoltage_lockout;
  always_comb begin
    tone_act_nxt = tone_act_r;
    dly_nxt = dly_r;
    ph_nxt = ph_r;
    tone_nxt = tone_r;
    if (!gate) begin
      tone_act_nxt = 1'b0;
      dly_nxt = '0;
    end else if (env != tone_act_r) begin
      // Delay differs by direction: short start, held stop
      if (env && dly_r == 11'(TON_D - 1)) begin
        tone_act_nxt = 1'b1;
        dly_nxt = '0;
      end else if (!env && dly_r == 11'(PROTECT_OFF_TIME_D - 1)) begin
        tone_act_nxt = 1'b0;
        dly_nxt = '0;
      end else begin
        dly_nxt = dly_r + 11'h001;
      end
    end else begin
      dly_nxt = '0;
    end
    if (tone_act_r) begin
      if (ph_r == 10'(HALF - 1)) begin
        ph_nxt = '0;
        tone_nxt = !tone_r;
      end else begin
        ph_nxt = ph_r + 10'h001;
      end
    end else begin
      ph_nxt = '0;
      tone_nxt = 1'b0;
    end
  end
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tone_act_r <= 1'b0;
      dly_r <= '0;
      ph_r <= '0;
      tone_r <= 1'b0;
    end else if (clk_en_i) begin
      tone_act_r <= tone_act_nxt;
      dly_r <= dly_nxt;
      ph_r <= ph_nxt;
      tone_r <= tone_nxt;
    end
  end

  // ==========================================================
  // Per-section protection
  lsp_prot_t st_r [2];
  lsp_prot_t st_nxt [2];
  logic [CNT_W-1:0] cnt_r [2];
  logic [CNT_W-1:0] cnt_nxt [2];
  logic [1:0] sec_on;
  logic [1:0] oc_ev;
  generate
    for (g = 0; g < 2; g++) begin : g_sec
      always_comb begin
        st_nxt[g] = st_r[g];
        cnt_nxt[g] = cnt_r[g] + CNT_W'(1);
        oc_ev[g] = 1'b0;
        unique case (st_r[g])
          LSP_NORMAL: begin
            cnt_nxt[g] = '0;
            if (oload[g]) begin
              oc_ev[g] = 1'b1;
              if (!pulsed_limit_select_i[g]) begin
                st_nxt[g] = LSP_ON;
              end
            end
          end
          LSP_ON, LSP_RETRY: begin
            if (cnt_r[g] == CNT_W'(TON_CYC - 1)) begin
              cnt_nxt[g] = '0;
              if (oload[g]) begin
                st_nxt[g] = LSP_OFF;
              end else if (st_r[g] == LSP_RETRY) begin
                st_nxt[g] = LSP_NORMAL;
              end else begin
                st_nxt[g] = LSP_OFF;
              end
            end
            if (oload[g]) begin
              oc_ev[g] = 1'b1;
            end
          end
          LSP_OFF: begin
            if (cnt_r[g] == CNT_W'(PROTECT_OFF_TIME_CYC - 1)) begin
              cnt_nxt[g] = '0;
              st_nxt[g] = LSP_RETRY;
            end
          end
        endcase
        if (pulsed_limit_select_i[g] && st_r[g] != LSP_OFF) begin
          st_nxt[g] = LSP_NORMAL;
          cnt_nxt[g] = '0;
        end
        sec_on[g] = (st_r[g] != LSP_OFF);
      end
    end
  endgenerate
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      st_r[0] <= LSP_NORMAL;
      st_r[1] <= LSP_NORMAL;
      cnt_r[0] <= '0;
      cnt_r[1] <= '0;
    end else if (clk_en_i) begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // ==========================================================
  // Voltage register, recovery and diagnostics
  logic [7:0] vreg_r, vreg_nxt;
  logic [3:0] diag_r, diag_nxt;
  logic [3:0] cause;
  logic [1:0] oc_seen_r, oc_seen_nxt;
  logic [1:0] en_r, en_nxt;
  logic conv_r, conv_nxt;
  logic flt_r, flt_nxt;
  logic tone_o_r, tone_o_nxt;
  always_comb begin
    cause = '0;
    cause[`LSP_DIAG_OT] = otemp;
    cause[`LSP_DIAG_OC_A] = oload[0] || st_r[0] != LSP_NORMAL;
    cause[`LSP_DIAG_OC_B] = oload[1] || st_r[1] != LSP_NORMAL;
    cause[`LSP_DIAG_SL] = slow;
    vreg_nxt = vreg_r;
    oc_seen_nxt = oc_seen_r & oload;
    if (voltage_level_we_i) begin
      vreg_nxt = voltage_level_wdata_i;
    end
    if (overload_recovery_bit_i) begin
      if (oc_ev[0] && !oc_seen_r[0]) begin
        vreg_nxt[`LSP_VOLTAGE_SELECT_BITS_A_LSB +: `LSP_VOLTAGE_SELECT_BITS_W] = '0;
      end
      if (oc_ev[1] && !oc_seen_r[1]) begin
        vreg_nxt[`LSP_VOLTAGE_SELECT_BITS_B_LSB +: `LSP_VOLTAGE_SELECT_BITS_W] = '0;
      end
    end
    oc_seen_nxt = oc_seen_nxt | oc_ev;
    if (otemp && thermal_recovery_bit_i) begin
      vreg_nxt = '0;
    end
    if (undervoltage_lockout) begin
      vreg_nxt = '0;
    end
    // Set wins over clear; read only clears flags whose cause is gone
    diag_nxt = diag_r;
    if (diagnostic_rd_i) begin
      diag_nxt = diag_r & cause;
    end
    diag_nxt = diag_nxt | cause | {1'b0, oc_ev, 1'b0};
    // Automatic restart when recovery bits are 0 follows from cause removal
    // Section keeps supplying through the on-time; next level avoids a stale cycle
    en_nxt[0] = sec_on[0] && !otemp && !undervoltage_lockout &&
                (vreg_nxt[`LSP_VOLTAGE_SELECT_BITS_A_LSB +: `LSP_VOLTAGE_SELECT_BITS_W] != '0);
    en_nxt[1] = sec_on[1] && !otemp && !undervoltage_lockout &&
                (vreg_nxt[`LSP_VOLTAGE_SELECT_BITS_B_LSB +: `LSP_VOLTAGE_SELECT_BITS_W] != '0);
    conv_nxt = !otemp && !undervoltage_lockout && (vreg_nxt != '0);
    flt_nxt = !(|(oload & pulsed_limit_select_i));
    tone_o_nxt = tone_r && !otemp;
  end
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      vreg_r <= '0;
      diag_r <= '0;
      oc_seen_r <= '0;
      en_r <= '0;
      conv_r <= 1'b0;
      flt_r <= 1'b1;
      tone_o_r <= 1'b0;
    end else if (clk_en_i) begin
      vreg_r <= vreg_nxt;
      diag_r <= diag_nxt;
      oc_seen_r <= oc_seen_nxt;
      en_r <= en_nxt;
      conv_r <= conv_nxt;
      flt_r <= flt_nxt;
      tone_o_r <= tone_o_nxt;
    end
  end

  assign tone_out_o = tone_o_r;
  assign tone_active_o = tone_act_r;
  assign voltage_level_reg_o = vreg_r;
  assign output_enable_o = en_r;
  assign converter_enable_o = conv_r;
  assign diagnostic_reg_o = diag_r;
  assign fault_n_out_o = flt_r;

endmodule // lsp_control

// ---- logic/lsp_map.svh ----
// Constants and timing figures for the LNB supply protection control block
//
// What this block does
// - Envelope high gates internal tone when enabled
// - Tone starts about 6 us after rise
// - Tone stops 15 to 60 us after fall
// - Two 4-bit voltage fields in one register
// - Four diagnostic bits, zero when healthy
// - Overtemp, overcurrent A, B, supply-low flags
// - Flags hold until cause gone and read
// - Lockout ignores writes, zeroes data registers
// - Writes accepted once lockout releases
// - Supply-low detector sets supply-low flag
// - Limit select 1 static, 0 pulsed
// - Pulsed: 90 ms on, 900 ms off, flag
// - Retry on-time, repeat while overload persists
// - Clean retry on-time returns section to normal
// - Internal timer sets 990 ms period
// - Static clamp sets flag, drives fault low
// - Overload recovery 1 clears section voltage
// - Overload recovery 0 restarts automatically
// - Overtemp shuts converter and both regulators
// - Thermal recovery 1 clears all voltages
// - Thermal recovery 0 restarts automatically
`ifndef LSP_MAP_SVH
`define LSP_MAP_SVH

`define LSP_CLK_HZ 20000000
`define LSP_TONE_ON_NS 6000
`define LSP_TONE_OFF_NS 30000
`define LSP_TON_MS 90
`define LSP_PROTECT_OFF_TIME_MS 900
`define LSP_TONE_ON_CYC ((`LSP_TONE_ON_NS * (`LSP_CLK_HZ / 1000000) + 999) / 1000)
`define LSP_TONE_OFF_CYC ((`LSP_TONE_OFF_NS * (`LSP_CLK_HZ / 1000000)) / 1000)
`define LSP_TON_CYC (`LSP_TON_MS * (`LSP_CLK_HZ / 1000))
`define LSP_PROTECT_OFF_TIME_CYC (`LSP_PROTECT_OFF_TIME_MS * (`LSP_CLK_HZ / 1000))
`define LSP_VOLTAGE_SELECT_BITS_W 4
`define LSP_VOLTAGE_SELECT_BITS_A_LSB 0
`define LSP_VOLTAGE_SELECT_BITS_B_LSB 4
`define LSP_DIAG_OT 0
`define LSP_DIAG_OC_A 1
`define LSP_DIAG_OC_B 2
`define LSP_DIAG_SL 3
`define LSP_TONE_HALF_CYC 455

`endif

// ---- logic/lsp_pkg.sv ----
// Types for the LNB supply protection control block
package lsp_pkg;
  typedef enum logic [1:0] {
    LSP_NORMAL,
    LSP_ON,
    LSP_OFF,
    LSP_RETRY
  } lsp_prot_t;
endpackage

// ---- verif/lsp_control_checker.sv ----
// Concurrent checks on the protection control ports
module lsp_control_checker (
  // Clock and stimulus
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic tone_envelope_in_i,
  input wire logic undervoltage_lockout_i,
  input wire logic supply_low_detector_i,
  input wire logic overtemp_det_i,
  input wire logic [1:0] overload_det_i,
  input wire logic [1:0] pulsed_limit_select_i,
  input wire logic diagnostic_rd_i,
  // Observed outputs
  input wire logic tone_active_o,
  input wire logic [7:0] voltage_level_reg_o,
  input wire logic [1:0] output_enable_o,
  input wire logic converter_enable_o,
  input wire logic [3:0] diagnostic_reg_o,
  input wire logic fault_n_out_o
);
  // ==========
  // Properties
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  property p_lockout;
    undervoltage_lockout_i[*8] |=> voltage_level_reg_o == 8'h0;
  endproperty
  a_lockout: assert property (p_lockout) else $error("register not zero in lockout");
  property p_oe_needs_voltage_select_bits;
    (output_enable_o & ~{|voltage_level_reg_o[7:4], |voltage_level_reg_o[3:0]}) == 2'h0;
  endproperty
  a_oe_needs_voltage_select_bits: assert property (p_oe_needs_voltage_select_bits) else $error("output on with zero level");
  property p_ot_shut;
    overtemp_det_i[*8] |=> !converter_enable_o && output_enable_o == 2'h0 && diagnostic_reg_o[0];
  endproperty
  a_ot_shut: assert property (p_ot_shut) else $error("overtemp did not shut down");
  property p_sl_flag;
    supply_low_detector_i[*8] |=> diagnostic_reg_o[3];
  endproperty
  a_sl_flag: assert property (p_sl_flag) else $error("supply low flag missing");
  // Flags may only drop right after a status read
  property p_flag_hold;
    |($past(diagnostic_reg_o) & ~diagnostic_reg_o) |-> $past(diagnostic_rd_i) || $past(diagnostic_rd_i, 2);
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag cleared without read");
  property p_static_fault;
    (pulsed_limit_select_i[1] && overload_det_i[1])[*8] |=> !fault_n_out_o && diagnostic_reg_o[2];
  endproperty
  a_static_fault: assert property (p_static_fault) else $error("static clamp not flagged");
  property p_tone_start;
    $rose(tone_active_o) |-> $past(tone_envelope_in_i, 110);
  endproperty
  a_tone_start: assert property (p_tone_start) else $error("tone started too early");
  property p_tone_stop;
    $fell(tone_active_o) |-> !$past(tone_envelope_in_i, 290);
  endproperty
  a_tone_stop: assert property (p_tone_stop) else $error("tone stopped too early");
endmodule // lsp_control_checker

bind lsp_control lsp_control_checker i_lsp_control_checker (.clk_i, .reset_n_i,
  .tone_envelope_in_i, .undervoltage_lockout_i, .supply_low_detector_i, .overtemp_det_i,
  .overload_det_i, .pulsed_limit_select_i, .diagnostic_rd_i, .tone_active_o,
  .voltage_level_reg_o, .output_enable_o, .converter_enable_o, .diagnostic_reg_o,
  .fault_n_out_o);

// ---- verif/lsp_host_model.sv ----
// Host model issuing level writes and status reads
module lsp_host_model (
  // Clock
  input wire logic clk_i,
  // Register strobes
  output logic we_o,
  output logic [7:0] wdata_o,
  output logic rd_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========
  // Accesses
  initial begin
    we_o = 1'b0;
    wdata_o = 8'h0;
    rd_o = 1'b0;
  end
  // Data inverted when idle so stale values never look valid
  task automatic wr(input logic [7:0] d);
    @(negedge clk_i);
    we_o = 1'b1;
    wdata_o = d;
    @(negedge clk_i);
    we_o = 1'b0;
    wdata_o = ~d;
  endtask
  task automatic rd();
    @(negedge clk_i);
    rd_o = 1'b1;
    @(negedge clk_i);
    rd_o = 1'b0;
  endtask
endmodule // lsp_host_model

// ---- verif/tb_lsp_control.sv ----
// Self-checking bench for the protection control block
module tb_lsp_control;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int PROTECT_ON_TIME = 20;
  localparam int PROTECT_OFF_TIME = 200;
  logic clk, rst_n, env, ext, protect_on_time, overload_recovery_bit, thermal_recovery_bit, undervoltage_lockout, sld, ot, we, rd, tone_out, tone_act;
  logic conv, fault_n, t;
  logic [1:0] pls, ol, oe;
  logic [7:0] wd, vlr, d;
  logic [3:0] diag, mon;
  int seed, n, m, miscompares, n_compared;
  assign mon = {tone_act, oe, fault_n};
  lsp_control #(.TON_CYC(PROTECT_ON_TIME), .PROTECT_OFF_TIME_CYC(PROTECT_OFF_TIME)) i_lsp_control (.clk_i(clk), .reset_n_i(rst_n),
    .clk_en_i(1'b1), .tone_envelope_in_i(env), .external_tone_mode_i(ext), .tone_on_bit_i(protect_on_time),
    .voltage_level_we_i(we), .voltage_level_wdata_i(wd), .pulsed_limit_select_i(pls),
    .overload_recovery_bit_i(overload_recovery_bit), .thermal_recovery_bit_i(thermal_recovery_bit), .diagnostic_rd_i(rd),
    .undervoltage_lockout_i(undervoltage_lockout), .supply_low_detector_i(sld), .overtemp_det_i(ot),
    .overload_det_i(ol), .tone_out_o(tone_out), .tone_active_o(tone_act),
    .voltage_level_reg_o(vlr), .output_enable_o(oe), .converter_enable_o(conv),
    .diagnostic_reg_o(diag), .fault_n_out_o(fault_n));
  lsp_host_model i_lsp_host_model (.clk_i(clk), .we_o(we), .wdata_o(wd), .rd_o(rd));
  // ==========
  // Helpers
  function automatic logic [1:0] oe_exp(input logic [7:0] v);
    return {|v[7:4], |v[3:0]};
  endfunction
  task automatic chk(input logic ok, input string msg);
    n_compared++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask
  task automatic wait_bit(input int i, input logic v, output int c);
    c = 0;
    while (mon[i] !== v && c < 30000) begin
      @(negedge clk);
      c++;
    end
  endtask
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Hang guard well beyond the expected run
  initial begin
    repeat (40000) @(posedge clk);
    miscompares++;
    print_verdict();
  end
  // ==========
  // Scenarios
  initial begin
    seed = 56153;
    {env, ext, protect_on_time, pls, overload_recovery_bit, thermal_recovery_bit, undervoltage_lockout, sld, ot, ol} = '0;
    rst_n = 1'b0;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    repeat (8) @(negedge clk);
    chk(vlr === 8'h0 && diag === 4'h0 && fault_n === 1'b1, "reset values");
    undervoltage_lockout = 1'b1;
    repeat (10) @(negedge clk);
    i_lsp_host_model.wr(8'h55);
    repeat (3) @(negedge clk);
    chk(vlr === 8'h0 && oe === 2'h0, "write taken in lockout");
    undervoltage_lockout = 1'b0;
    repeat (10) @(negedge clk);
    for (int k = 0; k < 6; k++) begin
      d = (k == 0) ? 8'hf0 : 8'($random(seed));
      i_lsp_host_model.wr(d);
      @(negedge clk);
      chk(vlr === d && oe === oe_exp(d), "level write");
    end
    i_lsp_host_model.wr(8'h33);
    protect_on_time = 1'b1;
    env = 1'b1;
    wait_bit(3, 1'b1, n);
    chk(n >= 120 && n <= 140, "tone start delay");
    m = 0;
    for (int k = 0; k < 1000; k++) begin
      t = tone_out;
      @(negedge clk);
      m += int'(tone_out !== t);
    end
    chk(m >= 2 && m <= 3, "tone rate");
    env = 1'b0;
    wait_bit(3, 1'b0, n);
    chk(n >= 300 && n <= 1200, "tone stop delay");
    ext = 1'b1;
    env = 1'b1;
    repeat (200) @(negedge clk);
    chk(tone_act === 1'b0, "tone gated by mode");
    env = 1'b0;
    ext = 1'b0;
    pls = 2'b10;
    ol[0] = 1'b1;
    wait_bit(1, 1'b0, n);
    chk(n >= PROTECT_ON_TIME && n <= PROTECT_ON_TIME + 10 && diag[1] === 1'b1, "on-time");
    wait_bit(1, 1'b1, n);
    chk(n >= PROTECT_OFF_TIME - 2 && n <= PROTECT_OFF_TIME + 2, "off-time");
    chk(oe[1] === 1'b1, "other section untouched");
    wait_bit(1, 1'b0, n);
    chk(n >= PROTECT_ON_TIME - 2 && n <= PROTECT_ON_TIME + 2, "retry on-time");
    ol[0] = 1'b0;
    wait_bit(1, 1'b1, n);
    repeat (PROTECT_ON_TIME + 20) @(negedge clk);
    chk(oe[0] === 1'b1 && diag[1] === 1'b1, "clean retry");
    chk(vlr === 8'h33, "auto restart keeps level");
    i_lsp_host_model.rd();
    @(negedge clk);
    chk(diag[1] === 1'b0, "flag cleared by read");
    overload_recovery_bit = 1'b1;
    ol[1] = 1'b1;
    repeat (12) @(negedge clk);
    chk(fault_n === 1'b0 && diag[2] === 1'b1, "static clamp");
    ol[1] = 1'b0;
    repeat (12) @(negedge clk);
    chk(vlr === 8'h03 && oe === 2'b01, "recovery clears level");
    i_lsp_host_model.wr(8'h73);
    i_lsp_host_model.rd();
    @(negedge clk);
    chk(oe === 2'b11 && fault_n === 1'b1 && diag === 4'h0, "rewrite restarts");
    thermal_recovery_bit = 1'b1;
    ot = 1'b1;
    repeat (12) @(negedge clk);
    chk(conv === 1'b0 && oe === 2'h0 && diag[0] === 1'b1, "overtemp shutdown");
    ot = 1'b0;
    repeat (12) @(negedge clk);
    chk(vlr === 8'h0 && oe === 2'h0, "thermal recovery clears");
    i_lsp_host_model.wr(8'h42);
    thermal_recovery_bit = 1'b0;
    ot = 1'b1;
    repeat (12) @(negedge clk);
    ot = 1'b0;
    repeat (12) @(negedge clk);
    chk(oe === 2'b11 && conv === 1'b1 && vlr === 8'h42, "thermal auto restart");
    sld = 1'b1;
    i_lsp_host_model.rd();
    repeat (12) @(negedge clk);
    chk(diag === 4'b1000, "supply low flag");
    i_lsp_host_model.rd();
    @(negedge clk);
    chk(diag === 4'b1000, "flag held while cause present");
    sld = 1'b0;
    repeat (12) @(negedge clk);
    i_lsp_host_model.rd();
    @(negedge clk);
    chk(diag === 4'h0, "all flags low when healthy");
    print_verdict();
  end
endmodule // tb_lsp_control
